//--- dac_sample_clock_control_bench.sv
`timescale 1ns/1ns
module dac_sample_clock_control_bench;
  logic        clk;
  logic        resetn;
  logic        rd;
  logic        wr;
  logic        run_s;
  logic        run_d;
  logic        single;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [3:0]  be;
  logic        sck;
  logic        dck;
  logic [15:0] pa;
  logic [15:0] pb;
  logic [15:0] code;
  logic        wait_req;
  logic        upd;
  logic        dpr;
  logic        pd;
  logic        dp;
  logic        dn;
  logic        oe;
  logic        drv;
  logic        trm;
  int          err_count;
  int          tests_run;

  dscc_top i_dscc_top (
    .i_sys_clk                      (clk),
    .i_resetn                       (resetn),
    .i_avs_address                  (addr),
    .i_avs_read                     (rd),
    .i_avs_write                    (wr),
    .i_avs_writedata                (wdata),
    .i_avs_byteenable               (be),
    .o_avs_readdata                 (rdata),
    .o_avs_waitrequest              (wait_req),
    .i_sample_clock_pins            (sck),
    .i_data_clock_in_pins           (dck),
    .i_data_port_a_pins             (pa),
    .i_data_port_b_pins             (pb),
    .o_dac_code                     (code),
    .o_dac_update                   (upd),
    .o_data_path_reset              (dpr),
    .o_sample_clock_rx_powerdown    (pd),
    .o_divided_clock_out_p          (dp),
    .o_divided_clock_out_n          (dn),
    .o_divided_clock_out_oe         (oe),
    .o_divided_clock_drive_select   (drv),
    .o_divided_clock_termination_on (trm)
  );

  dscc_host_model #(.RES(16)) i_dscc_host_model (
    .i_sys_clk            (clk),
    .i_run_sample         (run_s),
    .i_run_data           (run_d),
    .i_single             (single),
    .o_sample_clock_pins  (sck),
    .o_data_clock_in_pins (dck),
    .o_port_a             (pa),
    .o_port_b             (pb)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // entered just after a rising edge; leaves one edge after release
  // waits as long as the slave asks; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= ~w;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset_state;
    chk({31'h0, wait_req}, 32'h1);
    chk({29'h0, oe, drv, trm}, 32'h4);
    chk({28'h0, pd, dpr, dp, dn}, 32'h5);
    chk({16'h0, code}, 32'h0);
    bus(1'b0, 8'h08, 32'h0, v);
    chk(v, 32'h0);
  endtask

  task automatic t_present;
    int n;
    logic [31:0] q;
    n = 0;
    q = '0;
    while (q[1] !== 1'b1 && n < 30) begin
      bus(1'b0, 8'h08, 32'h0, q);
      n++;
    end
    chk({31'h0, q[1]}, 32'h1);
    chk({31'h0, dpr}, 32'h0);
  endtask

  task automatic period_of_p(output int per);
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) n = 0;
      while (dp !== k[0] && n < 99) begin
        @(posedge clk);
        n++;
      end
    end
    per = n;
  endtask

  // sample tick every 8 cycles: quarter rate is 32, half is 16
  task automatic t_divider;
    int per;
    period_of_p(per);
    chk(per, 32);
    chk({31'h0, dp ^ dn}, 32'h1);
    bus(1'b1, 8'h08, 32'h20, v);
    period_of_p(per);
    chk(per, 16);
    bus(1'b1, 8'h08, 32'h00, v);
  endtask

  task automatic t_ctl;
    bus(1'b1, 8'h08, 32'hFF, v);
    repeat (3) @(posedge clk);
    bus(1'b0, 8'h08, 32'h0, v);
    chk(v, 32'hF1);
    chk({27'h0, oe, drv, trm, pd, dpr}, 32'h0F);
    chk({30'h0, dp, dn}, 32'h1);
    be <= 4'h0;
    bus(1'b1, 8'h08, 32'h00, v);
    be <= 4'hF;
    bus(1'b0, 8'h08, 32'h0, v);
    chk(v, 32'hF1);
    bus(1'b0, 8'h20, 32'h0, v);
    chk(v, 32'h0);
    bus(1'b1, 8'h08, 32'h00, v);
    t_present();
  endtask

  task automatic t_stream(input logic sp);
    logic [15:0] q[$];
    int n;
    int ups;
    n = 0;
    ups = 0;
    single <= sp;
    bus(1'b1, 8'h10, {31'h0, sp}, v);
    repeat (80) begin
      @(posedge clk);
      if (upd === 1'b1) ups++;
    end
    chk(ups, 10);
    run_d <= 1'b1;
    while (q.size() < 12 && n < 600) begin
      @(posedge clk);
      n++;
      if (upd === 1'b1 && code !== 16'h0) q.push_back(code);
    end
    run_d <= 1'b0;
    chk(q.size(), 12);
    chk(q[0], 32'h1);
    for (int i = 1; i < q.size(); i++) chk(q[i], q[i-1] + 16'h1);
    // let leftover words drain before the next mode
    repeat (120) @(posedge clk);
    bus(1'b0, 8'h0C, 32'h0, v);
    chk(v, 32'h2);
    bus(1'b0, 8'h10, 32'h0, v);
    chk(v, {31'h0, sp});
  endtask

  task automatic t_absent;
    int n;
    n = 0;
    run_s <= 1'b0;
    while (dpr !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, dpr}, 32'h1);
    @(posedge clk);
    chk({16'h0, code}, 32'h0);
    bus(1'b0, 8'h08, 32'h0, v);
    chk(v, 32'h0);
  endtask

  initial begin
    resetn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'hF;
    run_s = 1'b0;
    run_d = 1'b0;
    single = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset_state();
    run_s <= 1'b1;
    t_present();
    t_divider();
    t_ctl();
    t_stream(1'b0);
    t_stream(1'b1);
    t_absent();
    end_of_test();
  end

  initial begin
    #2000000;
    err_count++;
    end_of_test();
  end
endmodule // dac_sample_clock_control_bench

//--- dscc_consts.svh
`ifndef DSCC_CONSTS_SVH
`define DSCC_CONSTS_SVH

// register indices; byte address is index times four
`define DSCC_CLKCTL_IDX       6'h02
`define DSCC_STATUS_IDX       6'h03
`define DSCC_MODE_IDX         6'h04

// clock control field positions
`define DSCC_BIT_RX_PD        0
`define DSCC_BIT_PRESENT      1
`define DSCC_BIT_OUT_DISABLE  4
`define DSCC_BIT_HALF_SELECT  5
`define DSCC_BIT_DRIVE_SELECT 6
`define DSCC_BIT_TERM_ON      7

// status field positions
`define DSCC_BIT_OVERRUN      0
`define DSCC_BIT_FIFO_EMPTY   1
`define DSCC_BIT_FIFO_FULL    2

// mode field positions
`define DSCC_BIT_PORT_MODE    0

// reset values
`define DSCC_CLKCTL_RESET     8'h00
`define DSCC_MODE_RESET       1'h0

// defaults
`define DSCC_RESOLUTION       16
`define DSCC_FIFO_DEPTH       8
`define DSCC_DET_GAP_CYCLES   16

`endif

//--- dscc_host_model.sv
`timescale 1ns/1ns
module dscc_host_model #(
  parameter int RES = 16
) (
  input  wire logic           i_sys_clk,
  input  wire logic           i_run_sample,
  input  wire logic           i_run_data,
  input  wire logic           i_single,
  output logic                o_sample_clock_pins,
  output logic                o_data_clock_in_pins,
  output logic      [RES-1:0] o_port_a,
  output logic      [RES-1:0] o_port_b
);
  logic [3:0]     cnt = 4'h0;
  logic [RES-1:0] word = '0;
  logic           armed = 1'b0;
  // data set half a frame before its edge, so it is stable on both sides
  wire            frame_start = i_single ? (cnt[2:0] == 3'h0) : (cnt == 4'h0);
  wire            edge_now = i_single ? (cnt[2:0] == 3'h4) : (cnt == 4'h8);

  initial begin
    o_sample_clock_pins = 1'b0;
    o_data_clock_in_pins = 1'b0;
    o_port_a = '0;
    o_port_b = '0;
  end

  always @(posedge i_sys_clk) begin
    cnt <= cnt + 4'h1;
    if (i_run_sample && cnt[1:0] == 2'h3) begin
      o_sample_clock_pins <= ~o_sample_clock_pins;
    end
    if (!i_run_data) begin
      armed    <= 1'b0;
      word     <= '0;
      // released lines invert every cycle instead of holding the last word
      o_port_a <= ~o_port_a;
      o_port_b <= ~o_port_b;
    end else if (frame_start) begin
      armed    <= 1'b1;
      o_port_a <= i_single ? ~(word + 1'b1) : word + 1'b1;
      o_port_b <= i_single ? word + 1'b1 : word + 2'h2;
      word     <= i_single ? word + 1'b1 : word + 2'h2;
    end else if (edge_now && armed) begin
      o_data_clock_in_pins <= ~o_data_clock_in_pins;
    end
  end
endmodule // dscc_host_model

//--- dscc_pkg.sv
package dscc_pkg;

  typedef enum logic [1:0] {
    DSCC_CAP_IDLE,
    DSCC_CAP_SEND_A,
    DSCC_CAP_SEND_B
  } dscc_cap_state_t;

  typedef enum logic {
    DSCC_BUS_IDLE,
    DSCC_BUS_ANSWER
  } dscc_bus_state_t;

endpackage

//--- dscc_top.sv
// Function
// - samples are two's complement, zero is mid-scale
// - code range spans full signed N-bit span
// - output updates once per sample clock cycle
// - present flag set only while fast clock seen
// - clock absent forces mid-scale, data path reset
// - present flag is bit 1, read only
// - bit 0 powers down sample clock receiver
// - receiver enabled after reset
// - bit 5 selects divide by two or four
// - divided clock active, quarter rate, low drive
// - bit 6 selects high drive current
// - bit 7 enables divided clock termination
// - bit 4 disables divided clock, high impedance
// - per data clock edge: one word in single mode, an A/B pair in dual
// - mode bit: single uses port B only
// - dual-port: port A word precedes port B
`timescale 1ns/1ns
`include "dscc_consts.svh"

module dscc_fifo #(
  parameter int WIDTH = `DSCC_RESOLUTION,
  parameter int DEPTH = `DSCC_FIFO_DEPTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output wire logic             o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_out_ready,
  output wire logic             o_out_valid,
  output wire logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_fifo
      $error("fifo depth must be a power of two of at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);
  wire              push  = i_in_valid && !full;
  wire              pop   = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // storage carries no reset; pointers alone define content
  always_ff @(posedge i_sys_clk) begin
    if (push) mem[wr_ptr[AW-1:0]] <= i_in_data;
  end
endmodule // dscc_fifo

module dscc_top #(
  parameter int RESOLUTION = `DSCC_RESOLUTION,
  parameter int FIFO_DEPTH = `DSCC_FIFO_DEPTH,
  parameter int DET_GAP    = `DSCC_DET_GAP_CYCLES
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_resetn,
  input  wire logic [7:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  input  wire logic                  i_sample_clock_pins,
  input  wire logic                  i_data_clock_in_pins,
  input  wire logic [RESOLUTION-1:0] i_data_port_a_pins,
  input  wire logic [RESOLUTION-1:0] i_data_port_b_pins,
  output logic      [RESOLUTION-1:0] o_dac_code,
  output logic                       o_dac_update,
  output logic                       o_data_path_reset,
  output logic                       o_sample_clock_rx_powerdown,
  output logic                       o_divided_clock_out_p,
  output logic                       o_divided_clock_out_n,
  output logic                       o_divided_clock_out_oe,
  output logic                       o_divided_clock_drive_select,
  output logic                       o_divided_clock_termination_on
);
  localparam int GW = $clog2(DET_GAP + 1);
  localparam logic [GW-1:0] GAP_MAX = GW'(DET_GAP);

  generate
    if (RESOLUTION != 16 && RESOLUTION != 14 && RESOLUTION != 11) begin : g_bad_res
      $error("resolution must be 16, 14 or 11");
    end
    if (DET_GAP < 2) begin : g_bad_gap
      $error("detector gap must be at least two cycles");
    end
  endgenerate

  // register bus
  dscc_pkg::dscc_bus_state_t bus_state;
  logic [7:0]                clkctl;
  logic                      port_mode;
  logic                      overrun;
  logic                      present;

  wire [7:0] clkctl_addr = {`DSCC_CLKCTL_IDX, 2'b00};
  wire [7:0] status_addr = {`DSCC_STATUS_IDX, 2'b00};
  wire [7:0] mode_addr   = {`DSCC_MODE_IDX, 2'b00};
  wire       hit_clkctl  = (i_avs_address == clkctl_addr);
  wire       hit_status  = (i_avs_address == status_addr);
  wire       hit_mode    = (i_avs_address == mode_addr);
  wire       bus_req     = i_avs_read || i_avs_write;
  wire       bus_load    = bus_req && (bus_state == dscc_pkg::DSCC_BUS_IDLE);
  wire       wr_commit   = i_avs_write && (bus_state == dscc_pkg::DSCC_BUS_ANSWER);
  wire       wr_byte0    = wr_commit && i_avs_byteenable[0];
  wire       fifo_empty;
  wire       fifo_full;

  // writable bits only; present and reserved bits are not stored
  wire [7:0] clkctl_wmask = 8'hF1;
  wire [7:0] next_clkctl  = i_avs_writedata[7:0] & clkctl_wmask;
  wire [7:0] clkctl_view  = {clkctl[7:4], 2'b00, present, clkctl[0]};

  wire [31:0] rd_clkctl = {24'h000000, clkctl_view};
  wire [31:0] rd_status = {29'h0, fifo_full, fifo_empty, overrun};
  wire [31:0] rd_mode   = {31'h0, port_mode};
  wire [31:0] next_readdata = hit_clkctl ? rd_clkctl :
                              hit_status ? rd_status :
                              hit_mode   ? rd_mode   : 32'h00000000;

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      bus_state         <= dscc_pkg::DSCC_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end else begin
      case (bus_state)
        dscc_pkg::DSCC_BUS_IDLE: begin
          if (bus_req) begin
            bus_state         <= dscc_pkg::DSCC_BUS_ANSWER;
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= next_readdata;
          end
        end
        dscc_pkg::DSCC_BUS_ANSWER: begin
          bus_state         <= dscc_pkg::DSCC_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state         <= dscc_pkg::DSCC_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      clkctl    <= `DSCC_CLKCTL_RESET;
      port_mode <= `DSCC_MODE_RESET;
    end else if (wr_byte0) begin
      if (hit_clkctl) clkctl <= next_clkctl;
      if (hit_mode) port_mode <= i_avs_writedata[`DSCC_BIT_PORT_MODE];
    end
  end

  wire rx_pd       = clkctl[`DSCC_BIT_RX_PD];
  wire out_disable = clkctl[`DSCC_BIT_OUT_DISABLE];
  wire half_select = clkctl[`DSCC_BIT_HALF_SELECT];

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_sample_clock_rx_powerdown    <= 1'b0;
      o_divided_clock_drive_select   <= 1'b0;
      o_divided_clock_termination_on <= 1'b0;
    end else begin
      o_sample_clock_rx_powerdown    <= rx_pd;
      o_divided_clock_drive_select   <= clkctl[`DSCC_BIT_DRIVE_SELECT];
      o_divided_clock_termination_on <= clkctl[`DSCC_BIT_TERM_ON];
    end
  end

  // sample clock receiver and detector
  logic [2:0]    sck_sync;
  logic          sck_level;
  logic [GW-1:0] gap;

  wire sck_agree = (sck_sync[1] == sck_sync[2]);
  // a powered-down receiver delivers no edges at all
  wire tick      = sck_agree && sck_sync[2] && !sck_level && !rx_pd;
  wire run_tick  = tick && present;

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      sck_sync  <= 3'h0;
      sck_level <= 1'b0;
    end else begin
      sck_sync <= {sck_sync[1:0], i_sample_clock_pins};
      if (sck_agree) sck_level <= sck_sync[2];
    end
  end

  // rate threshold becomes a maximum gap between rising edges
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || rx_pd) begin
      gap     <= GAP_MAX;
      present <= 1'b0;
    end else if (tick) begin
      gap     <= '0;
      present <= (gap < GAP_MAX);
    end else if (gap == GAP_MAX) begin
      present <= 1'b0;
    end else begin
      gap <= gap + 1'b1;
    end
  end

  // divided clock output
  logic half_cnt;
  logic div_q;

  wire div_toggle = tick && (half_select || half_cnt);

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || out_disable) begin
      half_cnt <= 1'b0;
      div_q    <= 1'b0;
    end else if (tick) begin
      half_cnt <= !half_cnt;
      if (div_toggle) div_q <= !div_q;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_divided_clock_out_p  <= 1'b0;
      o_divided_clock_out_n  <= 1'b1;
      o_divided_clock_out_oe <= 1'b1;
    end else begin
      o_divided_clock_out_p  <= div_q;
      o_divided_clock_out_n  <= !div_q;
      o_divided_clock_out_oe <= !out_disable;
    end
  end

  // data clock and port capture
  logic [2:0]            dck_sync;
  logic                  dck_level;
  logic [RESOLUTION-1:0] a_sync [3];
  logic [RESOLUTION-1:0] b_sync [3];
  logic [RESOLUTION-1:0] cap_a;
  logic [RESOLUTION-1:0] cap_b;

  dscc_pkg::dscc_cap_state_t cap_state;

  wire dck_agree = (dck_sync[1] == dck_sync[2]);
  // both edges of the data clock count
  wire dck_edge  = dck_agree && (dck_sync[2] != dck_level);

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      dck_sync  <= 3'h0;
      dck_level <= 1'b0;
    end else begin
      dck_sync <= {dck_sync[1:0], i_data_clock_in_pins};
      if (dck_agree) dck_level <= dck_sync[2];
    end
  end

  // data bits travel the same three stages as the clock
  genvar gs;
  generate
    for (gs = 0; gs < 3; gs++) begin : g_data_sync
      wire [RESOLUTION-1:0] a_src;
      wire [RESOLUTION-1:0] b_src;
      // stage zero reads the pins; no out-of-range index on the first stage
      if (gs == 0) begin : g_pin
        assign a_src = i_data_port_a_pins;
        assign b_src = i_data_port_b_pins;
      end else begin : g_chain
        assign a_src = a_sync[gs-1];
        assign b_src = b_sync[gs-1];
      end
      always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
          a_sync[gs] <= '0;
          b_sync[gs] <= '0;
        end else begin
          a_sync[gs] <= a_src;
          b_sync[gs] <= b_src;
        end
      end
    end
  endgenerate

  wire                  fifo_in_ready;
  wire                  fifo_out_valid;
  wire [RESOLUTION-1:0] fifo_out_data;
  wire                  sending  = (cap_state != dscc_pkg::DSCC_CAP_IDLE);
  wire [RESOLUTION-1:0] push_word = (cap_state == dscc_pkg::DSCC_CAP_SEND_A) ? cap_a : cap_b;
  wire                  pushed   = sending && fifo_in_ready;
  // an edge while a captured word is still unpushed is lost, room or not
  wire                  lost     = dck_edge && present && sending;
  wire                  clr_ovr  = wr_byte0 && hit_status && i_avs_writedata[`DSCC_BIT_OVERRUN];

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || !present) begin
      cap_state <= dscc_pkg::DSCC_CAP_IDLE;
      cap_a     <= '0;
      cap_b     <= '0;
    end else begin
      case (cap_state)
        dscc_pkg::DSCC_CAP_IDLE: begin
          if (dck_edge) begin
            cap_a <= a_sync[2];
            cap_b <= b_sync[2];
            if (port_mode) cap_state <= dscc_pkg::DSCC_CAP_SEND_B;
            else cap_state <= dscc_pkg::DSCC_CAP_SEND_A;
          end
        end
        dscc_pkg::DSCC_CAP_SEND_A: begin
          if (fifo_in_ready) cap_state <= dscc_pkg::DSCC_CAP_SEND_B;
        end
        dscc_pkg::DSCC_CAP_SEND_B: begin
          if (fifo_in_ready) cap_state <= dscc_pkg::DSCC_CAP_IDLE;
        end
        default: cap_state <= dscc_pkg::DSCC_CAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) overrun <= 1'b0;
    else if (lost) overrun <= 1'b1;
    else if (clr_ovr) overrun <= 1'b0;
  end

  dscc_fifo #(
    .WIDTH (RESOLUTION),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_resetn    (i_resetn),
    .i_flush     (!present),
    .i_in_valid  (sending),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (push_word),
    .i_out_ready (run_tick),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data)
  );

  assign fifo_empty = !fifo_out_valid;
  assign fifo_full  = !fifo_in_ready;

  // converter code output
  // all-zeros two's complement code is mid-scale; underrun also mutes
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn || !present) begin
      o_dac_code        <= '0;
      o_dac_update      <= 1'b0;
      o_data_path_reset <= 1'b1;
    end else begin
      o_dac_update      <= run_tick;
      o_data_path_reset <= 1'b0;
      if (run_tick) o_dac_code <= fifo_out_valid ? fifo_out_data : '0;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  chk_midscale_absent: assert property (
    !present |=> (o_dac_code == '0) && o_data_path_reset && !o_dac_update)
    else $error("output not muted while sample clock absent");

  chk_present_gap: assert property (
    (present && !tick && gap == GAP_MAX) |=> !present)
    else $error("present flag kept after gap");

  chk_present_pd: assert property (
    rx_pd |=> !present && o_sample_clock_rx_powerdown)
    else $error("receiver powered down but clock seen");

  chk_present_read: assert property (
    (bus_load && hit_clkctl && i_avs_read) |=> o_avs_readdata[1] == $past(present))
    else $error("present bit readback wrong");

  chk_present_ro: assert property (
    (wr_byte0 && hit_clkctl) |=> (clkctl[3:1] == 3'h0))
    else $error("read-only or reserved bit stored");

  chk_rx_pd_write: assert property (
    (wr_byte0 && hit_clkctl) |=> ##1 o_sample_clock_rx_powerdown == $past(i_avs_writedata[0], 2))
    else $error("receiver power-down not applied");

  chk_div_quarter: assert property (
    (tick && !half_select && !half_cnt && !out_disable) |=> $stable(div_q))
    else $error("quarter rate divider toggled early");

  chk_div_half: assert property (
    (tick && half_select && !out_disable) |=> $changed(div_q))
    else $error("half rate divider missed toggle");

  chk_drive_sel: assert property (
    (wr_byte0 && hit_clkctl) |=> ##1 o_divided_clock_drive_select == $past(i_avs_writedata[6], 2))
    else $error("drive select not applied");

  chk_term_on: assert property (
    (wr_byte0 && hit_clkctl) |=> ##1 o_divided_clock_termination_on == $past(i_avs_writedata[7], 2))
    else $error("termination not applied");

  chk_out_hiz: assert property (
    out_disable |=> !o_divided_clock_out_oe && !div_q)
    else $error("divided clock driven while disabled");

  chk_edge_capture: assert property (
    (dck_edge && present && !sending) |=> sending)
    else $error("data clock edge not captured");

  chk_single_port: assert property (
    (dck_edge && present && !sending && port_mode) |=> cap_state == dscc_pkg::DSCC_CAP_SEND_B)
    else $error("single port mode pushed port A");

  chk_pair_order: assert property (
    (cap_state == dscc_pkg::DSCC_CAP_SEND_A && fifo_in_ready && present)
      |=> cap_state == dscc_pkg::DSCC_CAP_SEND_B)
    else $error("port B word not after port A");

  chk_sample_update: assert property (
    run_tick |=> o_dac_update ##1 !o_dac_update)
    else $error("update not once per sample cycle");

  chk_reset_values: assert property (@(posedge i_sys_clk) disable iff (1'b0)
    !i_resetn |=> !o_sample_clock_rx_powerdown && o_divided_clock_out_oe && !o_divided_clock_drive_select)
    else $error("wrong values after reset");

  cov_dual_pair: cover property (
    cap_state == dscc_pkg::DSCC_CAP_SEND_A ##1 cap_state == dscc_pkg::DSCC_CAP_SEND_B);
  cov_present_rise: cover property (!present ##1 present);
  cov_fifo_full: cover property (fifo_full && present);
  cov_overrun: cover property ($rose(overrun));
endmodule // dscc_top
